//--- rtl/data_signal_modulator_cfg.svh
// Register map, field positions, reset values and codes of the signal mixer
`ifndef DATA_SIGNAL_MODULATOR_CFG_SVH
`define DATA_SIGNAL_MODULATOR_CFG_SVH

`define CTRL0_INDEX        12'hF51
`define CTRL1_INDEX        12'hF52
`define MOD_SRC_INDEX      12'hF53
`define LOW_CAR_INDEX      12'hF54
`define HIGH_CAR_INDEX     12'hF55
`define ADDR_OF(idx)       ({2'b00, idx, 2'b00})

`define ENABLE_BIT         7
`define OUT_LEVEL_BIT      5
`define FINAL_POL_BIT      4
`define SOFT_MOD_BIT       0
`define HIGH_INV_BIT       5
`define HIGH_WAIT_BIT      4
`define LOW_INV_BIT        1
`define LOW_WAIT_BIT       0

`define CTRL0_RESET        8'h00
`define CTRL1_RESET        8'h00
`define MOD_SRC_RESET      4'h0
`define LOW_CAR_RESET      3'h0
`define HIGH_CAR_RESET     3'h0

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- rtl/data_signal_modulator_pkg.sv
// Types shared by the signal mixer and its bench
package data_signal_modulator_pkg;

  // Field order follows the select code: first member is code 7
  typedef struct packed {
    logic pulseGenFour;
    logic pulseGenThree;
    logic compareUnitTwo;
    logic compareUnitOne;
    logic referenceClockOutput;
    logic internalFastOscillator;
    logic systemClockSource;
    logic pinRoute;
  } carrier_sources_t;

  // Codes 13 down to 2, then code 0; code 1 is the software bit
  typedef struct packed {
    logic syncSerialTwo;
    logic syncSerialOne;
    logic asyncSerialTwoTx;
    logic asyncSerialTwoRx;
    logic asyncSerialOneTx;
    logic asyncSerialOneRx;
    logic comparatorTwo;
    logic comparatorOne;
    logic pulseGenFour;
    logic pulseGenThree;
    logic compareUnitTwo;
    logic compareUnitOne;
    logic modSourcePinRoute;
  } mod_sources_t;

  typedef enum logic [1:0] {
    CARRIER_LOW  = 2'b01,
    CARRIER_HIGH = 2'b10
  } carrier_state_t;

endpackage : data_signal_modulator_pkg

//--- rtl/data_signal_modulator.sv
// Signal mixer unit: carrier/modulator mixing with an AXI4-Lite register slave
`timescale 1ns/10ps
`include "data_signal_modulator_cfg.svh"

module data_signal_modulator
  import data_signal_modulator_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [15:0]      awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  input  wire logic [15:0]      araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  input  wire carrier_sources_t highCarrierSources,
  input  wire carrier_sources_t lowCarrierSources,
  input  wire mod_sources_t     modSources,
  output logic                  modulatedOutputPin
);

  // Register fields
  logic           enable;
  logic           finalPolarityInvert;
  logic           softModSource;
  logic           highCarrierInvert;
  logic           highCarrierEdgeWait;
  logic           lowCarrierInvert;
  logic           lowCarrierEdgeWait;
  logic [3:0]     modSourceSel;
  logic [2:0]     lowCarrierSel;
  logic [2:0]     highCarrierSel;

  // Bus slave state
  logic           awHeld;
  logic           wHeld;
  logic [15:0]    awAddrQ;
  logic [7:0]     wByteQ;
  logic           wLaneQ;

  // Mixer state
  carrier_state_t carrierState;
  carrier_state_t next_carrierState;
  logic           prevHigh;
  logic           prevLow;

  // Maps an address to a register slot; 7 marks an unmapped address
  function automatic logic [2:0] regSlot(input logic [15:0] addr);
    logic [2:0] slot;
    slot = 3'h7;
    case (addr)
      `ADDR_OF(`CTRL0_INDEX):    slot = 3'h0;
      `ADDR_OF(`CTRL1_INDEX):    slot = 3'h1;
      `ADDR_OF(`MOD_SRC_INDEX):  slot = 3'h2;
      `ADDR_OF(`LOW_CAR_INDEX):  slot = 3'h3;
      `ADDR_OF(`HIGH_CAR_INDEX): slot = 3'h4;
      default:                   slot = 3'h7;
    endcase
    return slot;
  endfunction : regSlot

  // Write channel: address and data taken in either order
  wire        awTake   = awvalid & awready;
  wire        wTake    = wvalid & wready;
  wire        doWrite  = awHeld & wHeld;
  wire [2:0]  wrSlot   = regSlot(awAddrQ);
  wire        wrHit    = doWrite & wLaneQ & (wrSlot != 3'h7);
  wire [2:0]  rdSlot   = regSlot(araddr);
  wire        arTake   = arvalid & arready;

  assign awready = ~awHeld & ~bvalid;
  assign wready  = ~wHeld & ~bvalid;
  assign arready = ~rvalid;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHeld  <= 1'b0;
      awAddrQ <= 16'h0000;
    end
    else if (awTake)
    begin
      awHeld  <= 1'b1;
      awAddrQ <= awaddr;
    end
    else if (doWrite)
    begin
      awHeld  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wHeld  <= 1'b0;
      wByteQ <= 8'h00;
      wLaneQ <= 1'b0;
    end
    else if (wTake)
    begin
      wHeld  <= 1'b1;
      wByteQ <= wdata[7:0];
      wLaneQ <= wstrb[0];
    end
    else if (doWrite)
    begin
      wHeld  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp  <= (wrSlot == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // Register file; all fields return to defaults on reset
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      enable              <= 1'(`CTRL0_RESET >> `ENABLE_BIT);
      finalPolarityInvert <= 1'(`CTRL0_RESET >> `FINAL_POL_BIT);
      softModSource       <= 1'(`CTRL0_RESET >> `SOFT_MOD_BIT);
      highCarrierInvert   <= 1'(`CTRL1_RESET >> `HIGH_INV_BIT);
      highCarrierEdgeWait <= 1'(`CTRL1_RESET >> `HIGH_WAIT_BIT);
      lowCarrierInvert    <= 1'(`CTRL1_RESET >> `LOW_INV_BIT);
      lowCarrierEdgeWait  <= 1'(`CTRL1_RESET >> `LOW_WAIT_BIT);
      modSourceSel        <= `MOD_SRC_RESET;
      lowCarrierSel       <= `LOW_CAR_RESET;
      highCarrierSel      <= `HIGH_CAR_RESET;
    end
    else if (wrHit)
    begin
      case (wrSlot)
        3'h0:
        begin
          enable              <= wByteQ[`ENABLE_BIT];
          finalPolarityInvert <= wByteQ[`FINAL_POL_BIT];
          softModSource       <= wByteQ[`SOFT_MOD_BIT];
        end
        3'h1:
        begin
          highCarrierInvert   <= wByteQ[`HIGH_INV_BIT];
          highCarrierEdgeWait <= wByteQ[`HIGH_WAIT_BIT];
          lowCarrierInvert    <= wByteQ[`LOW_INV_BIT];
          lowCarrierEdgeWait  <= wByteQ[`LOW_WAIT_BIT];
        end
        3'h2:    modSourceSel   <= wByteQ[3:0];
        3'h3:    lowCarrierSel  <= wByteQ[2:0];
        3'h4:    highCarrierSel <= wByteQ[2:0];
        default: modSourceSel   <= modSourceSel;
      endcase
    end
  end

  // Read data
  wire [7:0] ctrl0Read = {enable, 1'b0, modulatedOutputPin, finalPolarityInvert,
                          3'h0, softModSource};
  wire [7:0] ctrl1Read = {2'h0, highCarrierInvert, highCarrierEdgeWait,
                          2'h0, lowCarrierInvert, lowCarrierEdgeWait};
  wire [7:0] readByte  = (rdSlot == 3'h0) ? ctrl0Read :
                         (rdSlot == 3'h1) ? ctrl1Read :
                         (rdSlot == 3'h2) ? {4'h0, modSourceSel} :
                         (rdSlot == 3'h3) ? {5'h00, lowCarrierSel} :
                         (rdSlot == 3'h4) ? {5'h00, highCarrierSel} : 8'h00;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end
    else if (arTake)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, readByte};
      rresp  <= (rdSlot == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (rready)
    begin
      rvalid <= 1'b0;
    end
  end

  // Source selection and carrier polarity
  wire highCarrier = highCarrierSources[highCarrierSel] ^ highCarrierInvert;
  wire lowCarrier  = lowCarrierSources[lowCarrierSel] ^ lowCarrierInvert;

  // Software bit sits at code 1; reserved codes read as low
  wire [15:0] modVector = {2'b00, modSources[12:1], softModSource,
                           modSources.modSourcePinRoute};
  wire        modulator = modVector[modSourceSel];

  // Falling edges after inversion
  wire highFall = prevHigh & ~highCarrier;
  wire lowFall  = prevLow & ~lowCarrier;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prevHigh <= 1'b0;
      prevLow  <= 1'b0;
    end
    else
    begin
      prevHigh <= highCarrier;
      prevLow  <= lowCarrier;
    end
  end

  // Carrier choice; sync holds the old carrier until its first fall
  always_comb
  begin
    next_carrierState = carrierState;
    case (carrierState)
      CARRIER_HIGH:
      begin
        if (~modulator & (~highCarrierEdgeWait | highFall))
        begin
          next_carrierState = CARRIER_LOW;
        end
      end
      CARRIER_LOW:
      begin
        if (modulator & (~lowCarrierEdgeWait | lowFall))
        begin
          next_carrierState = CARRIER_HIGH;
        end
      end
      default:
      begin
        next_carrierState = CARRIER_LOW;
      end
    endcase
    if (~enable)
    begin
      next_carrierState = CARRIER_LOW;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      carrierState <= CARRIER_LOW;
    end
    else
    begin
      carrierState <= next_carrierState;
    end
  end

  // Mixed output; switching without sync takes effect in the same cycle
  wire activeCarrier = (next_carrierState == CARRIER_HIGH) ? highCarrier
                                                           : lowCarrier;
  wire next_modulatedOutputPin = enable ? (activeCarrier ^ finalPolarityInvert)
                                        : 1'b0;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      modulatedOutputPin <= 1'b0;
    end
    else
    begin
      modulatedOutputPin <= next_modulatedOutputPin;
    end
  end

endmodule : data_signal_modulator

//--- dv/data_signal_modulator_checker.sv
// Port checks of the signal mixer
`timescale 1ns/10ps
`include "data_signal_modulator_cfg.svh"
module data_signal_modulator_checker (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [15:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        modulatedOutputPin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  rd_drop_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  wr_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered");
  out_read_a: assert property (arvalid && arready && araddr == `ADDR_OF(`CTRL0_INDEX)
    |=> rdata[`OUT_LEVEL_BIT] == $past(modulatedOutputPin)) else $error("level read wrong");
  bad_read_a: assert property (arvalid && arready && araddr == 16'h0000
    |=> rresp == `RESP_SLVERR && rdata == 32'h0) else $error("unmapped read accepted");
  rst_idle_a: assert property ($fell(sys_rst) |-> !modulatedOutputPin)
    else $error("output active after reset");
  wr_seen_c: cover property (bvalid && bready);
  rd_seen_c: cover property (rvalid && rready);
  rd_wait_c: cover property (rvalid && !rready);
  pin_high_c: cover property (modulatedOutputPin);
endmodule : data_signal_modulator_checker

bind data_signal_modulator data_signal_modulator_checker i_chk (.core_clk(core_clk),
  .sys_rst(sys_rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .modulatedOutputPin(modulatedOutputPin));

//--- dv/signal_source_model.sv
// Carrier and modulator sources beside the mixer
`timescale 1ns/10ps
module signal_source_model
  import data_signal_modulator_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        slow,
  output carrier_sources_t highSrc = '0,
  output carrier_sources_t lowSrc = '0,
  output mod_sources_t     modSrc = '0
);
  logic [2:0] tick = 3'h0;
  // Fast sources change every cycle, slow ones every eighth
  always @(posedge core_clk)
  begin
    tick <= tick + 3'h1;
    if (!slow || tick == 3'h0)
    begin
      highSrc <= 8'($urandom);
      lowSrc <= 8'($urandom);
      modSrc <= 13'($urandom);
    end
  end
endmodule : signal_source_model

//--- dv/data_signal_modulator_tb_top.sv
// Self-checking bench of the signal mixer
`timescale 1ns/10ps
`include "data_signal_modulator_cfg.svh"
`define CHK(n, e, s) begin nChecks++; if ((s) !== (e)) begin errTotal++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module data_signal_modulator_tb_top
  import data_signal_modulator_pkg::*;
;
  localparam logic [15:0] B = `ADDR_OF(`CTRL0_INDEX);
  logic             core_clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, chk = 1'b0;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic             rready = 1'b0, awready, wready, bvalid, arready, rvalid, pin, p;
  logic [15:0]      awaddr = '0, araddr = '0;
  logic [31:0]      wdata = '0, rdata;
  logic [1:0]       bresp, rresp, eb;
  logic [33:0]      er;
  logic [7:0]       sh [5];
  logic             hc, lc, m, ns, st = 1'b0, hp = 1'b0, lp = 1'b0;
  logic             pq [$];
  logic [1:0]       bq [$];
  logic [33:0]      rq [$];
  logic [2:0]       wrIdx = 3'h0;
  logic [7:0]       wrVal = 8'h00;
  logic             wrPend = 1'b0;
  carrier_sources_t hiSrc, loSrc;
  mod_sources_t     modSrc;
  int               errTotal = 0, nChecks = 0;

  always #2 core_clk = ~core_clk;

  data_signal_modulator i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .highCarrierSources(hiSrc), .lowCarrierSources(loSrc),
    .modSources(modSrc), .modulatedOutputPin(pin));
  signal_source_model i_src (.core_clk(core_clk), .slow(slow), .highSrc(hiSrc),
    .lowSrc(loSrc), .modSrc(modSrc));

  // Expected pin level for the next edge
  always @(posedge core_clk)
  begin
    // A write reaches the mixer at the edge where its response first shows
    if (wrPend && bvalid)
    begin
      sh[wrIdx] = wrVal;
      wrPend = 1'b0;
    end
    hc = hiSrc[sh[4][2:0]] ^ sh[1][5];
    lc = loSrc[sh[3][2:0]] ^ sh[1][1];
    m = sh[2][3:0] == 4'h1 ? sh[0][0] : sh[2][3:0] == 4'h0 ? modSrc[0] :
      sh[2][3:0] < 4'hE ? modSrc[sh[2][3:0] - 4'h1] : 1'b0;
    if (!sh[0][7] || sys_rst)
      ns = 1'b0;
    else if (st && !m)
      ns = sh[1][4] && !(hp && !hc);
    else if (!st && m)
      ns = !(sh[1][0] && !(lp && !lc));
    else
      ns = st;
    pq.push_back(sh[0][7] && !sys_rst ? (ns ? hc : lc) ^ sh[0][4] : 1'b0);
    st = ns;
    hp = hc;
    lp = lc;
  end

  always @(negedge core_clk)
  begin
    p = pq.pop_front();
    if (chk)
      `CHK("pin", p, pin)
  end

  always @(posedge core_clk)
  begin
    if (bvalid && bready)
    begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready)
    begin
      er = rq.pop_front();
      `CHK("rdata", er, {rresp, rdata})
    end
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge core_clk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge core_clk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    wrIdx = 3'((a - B) >> 2);
    wrVal = d;
    wrPend = (r == `RESP_OKAY);
    // Late ready lets the response wait and be held
    repeat ($urandom % 4) @(posedge core_clk);
    bready <= 1'b1;
    do @(posedge core_clk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    repeat ($urandom % 4) @(posedge core_clk);
    rready <= 1'b1;
    do @(posedge core_clk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  task automatic rst();
    chk = 1'b0;
    wrPend = 1'b0;
    sys_rst <= 1'b1;
    foreach (sh[k]) sh[k] = 8'h00;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask : rst

  task automatic final_report();
    if (errTotal == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    void'($urandom(99));
    rst();
    for (int k = 0; k < 5; k++) rd(B + 16'(k * 4), 34'h0);
    rd(16'h0000, {`RESP_SLVERR, 32'h0});
    wr(16'h0000, 8'hFF, `RESP_SLVERR);
    wr(B + 16'h4, 8'hFF, `RESP_OKAY);
    rd(B + 16'h4, 34'h33);
    wr(B, 8'h31, `RESP_OKAY);
    rd(B, 34'h11);
    for (int i = 0; i < 32; i++)
    begin
      chk = 1'b0;
      slow <= i[0];
      wr(B, 8'h00, `RESP_OKAY);
      wr(B + 16'h8, 8'(i % 16), `RESP_OKAY);
      wr(B + 16'hC, 8'(i), `RESP_OKAY);
      wr(B + 16'h10, 8'(~i), `RESP_OKAY);
      wr(B + 16'h4, 8'($urandom), `RESP_OKAY);
      wr(B, {1'b1, 2'b0, 1'($urandom), 3'b0, 1'($urandom)}, `RESP_OKAY);
      repeat (24) @(posedge core_clk);
      chk = 1'b1;
      repeat (48) @(posedge core_clk);
    end
    wr(B, 8'h00, `RESP_OKAY);
    rd(B + 16'h8, 34'h0F);
    rd(B + 16'hC, 34'h07);
    wr(B, 8'h80, `RESP_OKAY);
    rst();
    rd(B, 34'h0);
    rd(B + 16'h8, 34'h0);
    final_report();
  end

  initial
  begin
    #80000;
    errTotal++;
    final_report();
  end
endmodule : data_signal_modulator_tb_top
